/* coes_slave.sv */
// I2C write-only slave holding three output enable groups and gating six clocks
`timescale 1ns/1ps
`default_nettype none
`include "coes_params.svh"

module coes_slave #(
  parameter int unsigned HOLD_LIMIT_CYC = `COES_HOLD_LIMIT_CYC
) (
  input  wire logic          CLK,
  input  wire logic          RESETN,
  input  wire logic          SCL_IN,
  input  wire logic          SDA_IN,
  output logic               SDA_OUT,
  output logic               SDA_OE_N,
  input  wire logic          POWER_DOWN_MODE,
  input  wire logic          FANOUT_CLOCK_IN,
  output logic               FANOUT_CLOCK_OUT_0,
  output logic               FANOUT_CLOCK_OUT_2,
  output logic               FANOUT_CLOCK_OUT_7,
  output logic               FANOUT_CLOCK_OUT_11,
  output logic               FANOUT_CLOCK_OUT_14,
  output logic               FANOUT_CLOCK_OUT_17,
  output coes_pkg::coes_byte_t OUTPUT_ENABLE_GROUP_A,
  output coes_pkg::coes_byte_t OUTPUT_ENABLE_GROUP_B,
  output coes_pkg::coes_byte_t OUTPUT_ENABLE_GROUP_C
);
  import coes_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic        scl_q;
  logic        sda_q;
  logic        clk_in_q;
  logic        pd_q;
  logic        scl_prev_ff;
  logic        sda_prev_ff;
  coes_state_e state_ff;
  coes_state_e nxt_state;
  logic [3:0]  bit_cnt_ff;
  logic [3:0]  nxt_bit_cnt;
  logic [5:0]  byte_idx_ff;
  logic [5:0]  nxt_byte_idx;
  coes_byte_t  shift_ff;
  coes_byte_t  count_ff;
  coes_byte_t  group_a_ff;
  coes_byte_t  group_b_ff;
  coes_byte_t  group_c_ff;
  logic        sda_drive_ff;
  logic        nxt_sda_drive;
  logic [31:0] hold_cnt_ff;
  coes_outs_t  en_req;
  coes_outs_t  en_applied_ff;
  coes_outs_t  nxt_en_applied;
  coes_outs_t  out_ff;
  logic        pd_sync_n;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  coes_pin_sync #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk    (CLK),
    .resetn (RESETN),
    .pin_in (SCL_IN),
    .pin_q  (scl_q)
  );

  coes_pin_sync #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk    (CLK),
    .resetn (RESETN),
    .pin_in (SDA_IN),
    .pin_q  (sda_q)
  );

  coes_pin_sync #(.RESET_VAL(1'b0)) u_sync_clk (
    .clk    (CLK),
    .resetn (RESETN),
    .pin_in (FANOUT_CLOCK_IN),
    .pin_q  (clk_in_q)
  );

  coes_pin_sync #(.RESET_VAL(1'b0)) u_sync_pd (
    .clk    (CLK),
    .resetn (RESETN),
    .pin_in (POWER_DOWN_MODE),
    .pin_q  (pd_q)
  );

  // ----------------------------------------------------------------------
  // Bus event decode
  // ----------------------------------------------------------------------
  function automatic logic coes_slot_hit(input logic [5:0] idx, input coes_byte_t cnt,
                                         input logic [1:0] slot);
    logic [5:0] want;
    want = `COES_IDX_FIRST_DATA + {4'h0, slot};
    coes_slot_hit = (idx == want) && (cnt > {6'h00, slot});
  endfunction : coes_slot_hit

  // Edges of the filtered lines
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_q;
      sda_prev_ff <= sda_q;
    end
  end

  wire scl_rise   = scl_q & ~scl_prev_ff;
  wire scl_fall   = ~scl_q & scl_prev_ff;
  // Start and stop only count while the clock line is high
  wire bus_start  = scl_q & scl_prev_ff & ~sda_q & sda_prev_ff;
  wire bus_stop   = scl_q & scl_prev_ff & sda_q & ~sda_prev_ff;
  // Power-down blocks the store path too, so no late byte lands in a group
  wire byte_done  = (state_ff == COES_RECV) & scl_fall & pd_sync_n &
                    (bit_cnt_ff == `COES_BITS_PER_BYTE);
  wire is_addr    = (byte_idx_ff == `COES_IDX_ADDR);
  // Write direction only; general call never matches the fixed address
  wire addr_ok    = (shift_ff[7:1] == `COES_SLAVE_ADDR) & ~shift_ff[0];
  wire ack_ok     = is_addr ? addr_ok : 1'b1;
  wire hold_over  = (hold_cnt_ff >= HOLD_LIMIT_CYC - 1);
  wire wr_a       = byte_done & coes_slot_hit(byte_idx_ff, count_ff, `COES_OFS_GROUP_A);
  wire wr_b       = byte_done & coes_slot_hit(byte_idx_ff, count_ff, `COES_OFS_GROUP_B);
  wire wr_c       = byte_done & coes_slot_hit(byte_idx_ff, count_ff, `COES_OFS_GROUP_C);
  wire wr_any     = wr_a | wr_b | wr_c;
  wire take_count = byte_done & (byte_idx_ff == `COES_IDX_COUNT);
  assign pd_sync_n = ~pd_q;

  // ----------------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------------
  // Next state; a start restarts at the address byte unless power-down is active
  always_comb begin
    nxt_state     = state_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_byte_idx  = byte_idx_ff;
    nxt_sda_drive = 1'b0;
    if (!pd_sync_n) begin
      nxt_state = COES_IDLE;
    end else if (bus_stop) begin
      nxt_state = COES_IDLE;
    end else if (bus_start) begin
      nxt_state    = COES_RECV;
      nxt_bit_cnt  = 4'h0;
      nxt_byte_idx = `COES_IDX_ADDR;
    end else begin
      case (state_ff)
        COES_IDLE: begin
          nxt_state = COES_IDLE;
        end
        COES_RECV: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            // Acknowledge drives low from this clock fall onward
            nxt_state     = ack_ok ? COES_ACK : COES_SKIP;
            nxt_sda_drive = ack_ok;
          end
        end
        COES_ACK: begin
          nxt_sda_drive = 1'b1;
          if (hold_over) begin
            nxt_state     = COES_SKIP;
            nxt_sda_drive = 1'b0;
          end else if (scl_fall) begin
            nxt_state     = COES_RECV;
            nxt_sda_drive = 1'b0;
            nxt_bit_cnt   = 4'h0;
            // Saturate so long blocks keep acking but store nothing
            if (byte_idx_ff != `COES_IDX_MAX) begin
              nxt_byte_idx = byte_idx_ff + 6'h01;
            end
          end
        end
        COES_SKIP: begin
          nxt_state = COES_SKIP;
        end
        default: begin
          nxt_state = COES_IDLE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff     <= COES_IDLE;
      bit_cnt_ff   <= 4'h0;
      byte_idx_ff  <= `COES_IDX_ADDR;
      sda_drive_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      bit_cnt_ff   <= nxt_bit_cnt;
      byte_idx_ff  <= nxt_byte_idx;
      sda_drive_ff <= nxt_sda_drive;
    end
  end

  // Shift in on clock rise, first bit lands at the top
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      shift_ff <= 8'h00;
    end else if ((state_ff == COES_RECV) && scl_rise) begin
      shift_ff <= {shift_ff[6:0], sda_q};
    end
  end

  // Byte count kept; command byte content is not looked at
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_ff <= 8'h00;
    end else if (bus_start) begin
      count_ff <= 8'h00;
    end else if (take_count) begin
      count_ff <= shift_ff;
    end
  end

  // Low-time guard on our own data drive
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_cnt_ff <= 32'h0000_0000;
    end else if (sda_drive_ff) begin
      hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
    end else begin
      hold_cnt_ff <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Enable groups
  // ----------------------------------------------------------------------
  // Unused bits kept as written so read-back matches; power-down keeps all
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      group_a_ff <= `COES_OE_RESET;
      group_b_ff <= `COES_OE_RESET;
      group_c_ff <= `COES_OE_RESET;
    end else begin
      if (wr_a) group_a_ff <= shift_ff;
      if (wr_b) group_b_ff <= shift_ff;
      if (wr_c) group_c_ff <= shift_ff;
    end
  end

  // Requested enables per output
  assign en_req = {group_c_ff[`COES_BIT_OUT17],
                   group_b_ff[`COES_BIT_OUT14],
                   group_b_ff[`COES_BIT_OUT11],
                   group_a_ff[`COES_BIT_OUT7],
                   group_a_ff[`COES_BIT_OUT2],
                   group_a_ff[`COES_BIT_OUT0]};
  // New enables only land while the input clock is low, so no runt pulse
  assign nxt_en_applied = clk_in_q ? en_applied_ff : en_req;

  // ----------------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------------
  // Outputs from flops; output lags the input pin by four to five sample cycles
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      en_applied_ff <= `COES_APPLIED_RESET;
      out_ff        <= 6'h00;
    end else begin
      en_applied_ff <= nxt_en_applied;
      out_ff        <= {6{clk_in_q}} & en_applied_ff;
    end
  end

  assign FANOUT_CLOCK_OUT_0    = out_ff[0];
  assign FANOUT_CLOCK_OUT_2    = out_ff[1];
  assign FANOUT_CLOCK_OUT_7    = out_ff[2];
  assign FANOUT_CLOCK_OUT_11   = out_ff[3];
  assign FANOUT_CLOCK_OUT_14   = out_ff[4];
  assign FANOUT_CLOCK_OUT_17   = out_ff[5];
  assign OUTPUT_ENABLE_GROUP_A = group_a_ff;
  assign OUTPUT_ENABLE_GROUP_B = group_b_ff;
  assign OUTPUT_ENABLE_GROUP_C = group_c_ff;
  // Open-drain data; clock line is never driven so it never stretches
  assign SDA_OUT               = 1'b0;
  assign SDA_OE_N              = ~sda_drive_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_addr_reject: assert property (@(posedge CLK) disable iff (!RESETN)
    (byte_done && is_addr && !pd_q && !bus_stop && !bus_start &&
     shift_ff != {`COES_SLAVE_ADDR, 1'b0}) |=> (state_ff == COES_SKIP) && SDA_OE_N)
    else $error("wrong address or read was acknowledged");

  chk_gencall_ignore: assert property (@(posedge CLK) disable iff (!RESETN)
    (byte_done && is_addr && shift_ff[7:1] == `COES_GENERAL_CALL) |=> SDA_OE_N)
    else $error("general call was acknowledged");

  chk_store_order: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_any |-> (byte_idx_ff - `COES_IDX_FIRST_DATA) == {4'h0, wr_c, wr_b})
    else $error("data byte stored in the wrong group");

  chk_valid_after_count: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_any |-> (byte_idx_ff >= `COES_IDX_FIRST_DATA) && ($countones({wr_a, wr_b, wr_c}) == 1))
    else $error("stored before the count byte was acknowledged");

  chk_drop_excess: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_any |-> ({2'b00, byte_idx_ff} - {2'b00, `COES_IDX_FIRST_DATA}) < count_ff)
    else $error("byte beyond the byte count was stored");

  chk_hold_limit: assert property (@(posedge CLK) disable iff (!RESETN)
    sda_drive_ff |-> hold_cnt_ff < HOLD_LIMIT_CYC)
    else $error("data line held low too long");

  chk_pd_release: assert property (@(posedge CLK) disable iff (!RESETN)
    pd_q |=> SDA_OE_N && $stable(group_a_ff) && $stable(group_b_ff) && $stable(group_c_ff))
    else $error("power-down did not release data or changed settings");

  chk_msb_first: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_ff == COES_RECV && scl_rise) |=> shift_ff[0] == $past(sda_q) &&
                                            shift_ff[7:1] == $past(shift_ff[6:0]))
    else $error("serial bit not shifted in order");

  chk_cfg_readback: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_b |=> OUTPUT_ENABLE_GROUP_B == $past(shift_ff))
    else $error("group shows stale value after write");

  chk_disabled_low: assert property (@(posedge CLK) disable iff (!RESETN)
    !en_applied_ff[5] [*2] |-> !FANOUT_CLOCK_OUT_17)
    else $error("disabled output not held low");

  chk_enable_follow: assert property (@(posedge CLK) disable iff (!RESETN)
    (en_applied_ff[0] && clk_in_q) |=> FANOUT_CLOCK_OUT_0)
    else $error("enabled output did not follow the input clock");

  chk_enable_glitchless: assert property (@(posedge CLK) disable iff (!RESETN)
    (en_applied_ff != $past(en_applied_ff)) |-> !$past(clk_in_q))
    else $error("enable changed while input clock high");

  chk_group_c_map: assert property (@(posedge CLK) disable iff (!RESETN)
    (!clk_in_q) |=> en_applied_ff[5] == $past(group_c_ff[`COES_BIT_OUT17]))
    else $error("group C bit 7 does not gate output seventeen");

endmodule : coes_slave

`default_nettype wire

/* coes_params.svh */
// Constants of the I2C clock output enable slave
// What this block does
// - Answer only address 1101001 with write direction
// - Data bytes fill groups A, B, C ascending
// - Data counts only after the count acknowledge
// - Command byte content is ignored
// - Bytes beyond byte count are dropped
// - Never hold data line low past 10 ms
// - General call address is not acknowledged
// - Power-down releases the data line, keeps all settings; clock outputs keep running
// - Bits arrive most significant first
// - Stored groups show the last written value
// - Enable bit one runs output, zero stops
// - Group A bits 7, 2, 0 gate outputs
// - Group B bits 6, 3 gate outputs
// - Group C bit 7 gates output seventeen
// - Disabled output stays steadily low
`ifndef COES_PARAMS_SVH
`define COES_PARAMS_SVH

// ----------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------
`define COES_SLAVE_ADDR     7'h69
`define COES_GENERAL_CALL   7'h00
`define COES_IDX_ADDR       6'h00
`define COES_IDX_COUNT      6'h02
`define COES_IDX_FIRST_DATA 6'h03
`define COES_IDX_MAX        6'h3f
`define COES_BITS_PER_BYTE  4'h8

// ----------------------------------------------------------------------
// Register offsets, reset values and field positions
// ----------------------------------------------------------------------
`define COES_OFS_GROUP_A    2'h0
`define COES_OFS_GROUP_B    2'h1
`define COES_OFS_GROUP_C    2'h2
`define COES_NUM_GROUPS     8'h03
`define COES_OE_RESET       8'hff
`define COES_APPLIED_RESET  6'h3f
`define COES_BIT_OUT0       0
`define COES_BIT_OUT2       2
`define COES_BIT_OUT7       7
`define COES_BIT_OUT11      3
`define COES_BIT_OUT14      6
`define COES_BIT_OUT17      7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define COES_CLK_MHZ        200
`define COES_HOLD_LIMIT_MS  10
`define COES_HOLD_LIMIT_CYC (`COES_HOLD_LIMIT_MS * 1000 * `COES_CLK_MHZ)

`endif

/* coes_pkg.sv */
// Types shared by the I2C clock output enable slave
package coes_pkg;

  typedef logic [7:0] coes_byte_t;
  typedef logic [5:0] coes_outs_t;

  typedef enum logic [1:0] {
    COES_IDLE,
    COES_RECV,
    COES_ACK,
    COES_SKIP
  } coes_state_e;

endpackage : coes_pkg

/* coes_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module coes_pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      pin_q
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  // Chain; only the second stage reads the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a level once two settled stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_ff <= RESET_VAL;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign pin_q = q_ff;

endmodule : coes_pin_sync

`default_nettype wire

/* coes_host_model.sv */
// I2C host controller model issuing block writes to the enable slave
`timescale 1ns/1ps
`default_nettype none

module coes_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  int q = 10;  // Quarter bit in clocks; the bench raises it for a slow host

  // Both lines released; the pull-ups hold them high between frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic wait_q(input int n);
    repeat (n * q) @(negedge clk);
  endtask : wait_q

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  // Start: data falls while the clock is high
  task automatic start_cond();
    wait_q(1);
    sda_low = 1'b1;
    wait_q(1);
    scl_low = 1'b1;
    wait_q(1);
  endtask : start_cond

  // Stop: data rises while the clock is high
  task automatic stop_cond();
    sda_low = 1'b1;
    wait_q(1);
    scl_low = 1'b0;
    wait_q(1);
    sda_low = 1'b0;
    wait_q(2);
  endtask : stop_cond

  // Byte MSB first, then the ack slot; a stall keeps the clock low before it
  task automatic send_byte(input logic [7:0] b, input int stall, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      wait_q(1);
      scl_low = 1'b0;
      wait_q(2);
      scl_low = 1'b1;
      wait_q(1);
    end
    sda_low = 1'b0;
    repeat (stall) @(negedge clk);
    wait_q(1);
    scl_low = 1'b0;
    wait_q(1);
    ack = (sda_line === 1'b0);
    wait_q(1);
    scl_low = 1'b1;
    wait_q(1);
  endtask : send_byte
endmodule : coes_host_model
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the I2C clock output enable slave
`timescale 1ns/1ps
`default_nettype none
`include "coes_params.svh"

module testbench;
  import coes_pkg::*;
  localparam int HOLD = 200;  // Short hold limit keeps the stall test brief

  logic       clk    = 1'b0;
  logic       resetn = 1'b0;
  logic       pd     = 1'b0;
  logic       ref_clk = 1'b0;
  wire logic  scl_low;
  wire logic  sda_low;
  logic       sda_out;
  logic       sda_oe_n;
  logic [5:0] outs;
  coes_byte_t grp_a;
  coes_byte_t grp_b;
  coes_byte_t grp_c;
  logic [7:0] exp_grp [3];
  int         mismatches = 0;
  int         n_compared = 0;
  int         run_len [6];
  int         low_cnt = 0;
  logic       mon_on  = 1'b0;

  // Open-drain wires: pulled high unless a party pulls low
  wire logic scl_line = ~scl_low;
  wire logic sda_line = ~(sda_low | (~sda_oe_n & ~sda_out));

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  // Offset keeps reference edges clear of system clock edges
  initial begin
    #1.3;
    forever #32 ref_clk = ~ref_clk;
  end

  coes_slave #(.HOLD_LIMIT_CYC(HOLD)) i_coes_slave (
    .CLK(clk), .RESETN(resetn), .SCL_IN(scl_line), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .POWER_DOWN_MODE(pd),
    .FANOUT_CLOCK_IN(ref_clk), .FANOUT_CLOCK_OUT_0(outs[0]), .FANOUT_CLOCK_OUT_2(outs[1]),
    .FANOUT_CLOCK_OUT_7(outs[2]), .FANOUT_CLOCK_OUT_11(outs[3]),
    .FANOUT_CLOCK_OUT_14(outs[4]), .FANOUT_CLOCK_OUT_17(outs[5]),
    .OUTPUT_ENABLE_GROUP_A(grp_a), .OUTPUT_ENABLE_GROUP_B(grp_b),
    .OUTPUT_ENABLE_GROUP_C(grp_c));

  coes_host_model i_coes_host_model (
    .clk(clk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Stored groups against the model
  task automatic chk_groups();
    chk("group_a", exp_grp[0], grp_a);
    chk("group_b", exp_grp[1], grp_b);
    chk("group_c", exp_grp[2], grp_c);
  endtask : chk_groups

  // One block write; stall_at names the byte whose ack slot is stretched
  task automatic frame(input logic [6:0] addr, input logic rw, input int cnt,
                       input int ndata, input int stall_at);
    logic       ack;
    logic       live;
    logic [7:0] b;
    logic [7:0] mask [3];
    mask = '{8'h85, 8'h48, 8'h80};
    live = (addr == `COES_SLAVE_ADDR) && !rw && !pd;
    i_coes_host_model.start_cond();
    i_coes_host_model.send_byte({addr, rw}, 0, ack);
    chk("addr_ack", {7'h0, live}, {7'h0, ack});
    for (int k = 0; k < ndata + 2; k++) begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'(cnt) : 8'($urandom);
      if (k >= 2 && k < 5) begin
        b = b & mask[k-2];
      end
      i_coes_host_model.send_byte(b, (k == stall_at) ? 300 : 0, ack);
      if (k == stall_at) begin
        live = 1'b0;
      end
      chk("byte_ack", {7'h0, live}, {7'h0, ack});
      if (live && k >= 2 && k - 2 < cnt && k < 5) begin
        exp_grp[k-2] = b;
      end
    end
    i_coes_host_model.stop_cond();
    chk_groups();
  endtask : frame

  // Enabled outputs must be seen high at least once, disabled ones stay low
  task automatic check_outs();
    logic [5:0] en;
    logic [5:0] seen;
    en = {exp_grp[2][7], exp_grp[1][6], exp_grp[1][3],
          exp_grp[0][7], exp_grp[0][2], exp_grp[0][0]};
    seen = '0;
    repeat (40) @(negedge clk);
    repeat (80) begin
      @(negedge clk);
      seen = seen | outs;
    end
    chk("fanout_run", {2'b0, en}, {2'b0, seen});
  endtask : check_outs

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // A short high run means an enable change cut a pulse
  // Off until reset settles: the release itself may clip the first pulse
  always @(negedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (!mon_on) begin
        run_len[i] <= 0;
      end else if (outs[i] === 1'b1) begin
        run_len[i] <= run_len[i] + 1;
      end else begin
        if (run_len[i] > 0 && run_len[i] < 5) chk("runt_pulse", 8'h05, 8'(run_len[i]));
        run_len[i] <= 0;
      end
    end
  end

  // Data line must not be held low past the limit
  always @(negedge clk) begin
    low_cnt <= (sda_oe_n === 1'b0) ? low_cnt + 1 : 0;
    if (low_cnt == HOLD + 10) chk("sda_hold", 8'h00, 8'h01);
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("mismatch run_time expected finish seen timeout");
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(99685));
    exp_grp = '{default: `COES_OE_RESET};
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    mon_on = 1'b1;
    chk_groups();
    check_outs();
    $display("test reset_defaults done");
    frame(`COES_SLAVE_ADDR, 1'b0, 3, 3, -1);
    check_outs();
    $display("test full_write done");
    frame(`COES_SLAVE_ADDR, 1'b0, 1, 4, -1);
    check_outs();
    $display("test short_count done");
    frame(7'($urandom_range(104, 1)), 1'b0, 3, 3, -1);
    frame(`COES_SLAVE_ADDR, 1'b1, 3, 3, -1);
    frame(7'h00, 1'b0, 3, 3, -1);
    $display("test refused_address done");
    pd = 1'b1;
    repeat (10) @(negedge clk);
    frame(`COES_SLAVE_ADDR, 1'b0, 3, 3, -1);
    pd = 1'b0;
    repeat (10) @(negedge clk);
    check_outs();
    $display("test power_down done");
    frame(`COES_SLAVE_ADDR, 1'b0, 3, 3, 1);
    $display("test stall_release done");
    for (int i = 0; i < 4; i++) begin
      i_coes_host_model.q = (i == 1) ? 25 : 10;
      frame(`COES_SLAVE_ADDR, 1'b0, $urandom_range(4, 1), $urandom_range(5, 1), -1);
      check_outs();
    end
    $display("test random_writes done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
